// [verilog/dram_port_access_refresh_ctl.v]
// access port and refresh request front end of a dram controller
// assumes host inputs synchronous to i_clock; mode bits held static
`timescale 1ns/1ps
`include "dram_port_regs.vh"
module dram_port_access_refresh_ctl (
  input  wire               i_clock,                    // controller clock
  input  wire               i_resetn,                   // async reset, low
  input  wire               i_access_mode,              // 0 latch, 1 strobe
  input  wire               i_ack_style_select,         // 1 acknowledge style
  input  wire [`WAIT_W-1:0] i_wait_count,               // programmed waits
  input  wire               i_addr_latch_en,            // capture enable
  input  wire               i_refresh_due_en,           // due output enable
  input  wire               i_long_period,              // 15 us interval
  input  wire               i_addr_strobe_n,            // strobe / latch en
  input  wire               i_chip_select_n,            // port select
  input  wire               i_access_hold_req_n,        // access hold
  input  wire               i_stall_extend_n,           // extend waits
  input  wire               i_ext_refresh_req_n,        // external refresh
  input  wire               i_internal_refresh_inhibit_n, // inhibit
  input  wire [`ADDR_W-1:0] i_address,                  // bank row column
  output reg  [`ADDR_W-1:0] o_address,                  // captured address
  output wire               o_access_row_strobe_n,      // access row strobe
  output reg                o_refresh_row_strobe_n,     // refresh row strobe
  output reg  [`ROW_CNT_W-1:0] o_refresh_row,           // refresh row
  output reg                o_refresh_active_n,         // refresh in progress
  output reg                o_refresh_due_n,            // interval elapsed
  output wire               o_transfer_ack_n            // wait or acknowledge
);
  localparam S_IDLE   = 2'd0; // nothing owns the dram
  localparam S_ACCESS = 2'd1; // host access owns strobes
  localparam S_REFRESH = 2'd2; // refresh owns strobes
  localparam S_RDONE  = 2'd3; // refresh strobe negated, close

  reg [1:0]  state;             // arbiter state
  reg [1:0]  next_state;        // next arbiter state
  reg        pending;           // access waiting for the dram
  reg        strobe_d;          // strobe level last cycle
  reg        int_req;           // internal refresh owed
  reg        ext_clear_d;       // edge detect for counter clear
  reg [2:0]  rcnt;              // refresh row strobe length
  reg [`WAIT_W:0] wcnt;         // wait state count
  reg        ack;               // access performed and waited out
  reg        row_reg;           // registered access row strobe
  wire       tick;              // interval pulse

  // host strobe qualified by the port select; no host access starts without it
  wire strobe_on    = !i_addr_strobe_n && !i_chip_select_n;
  // first cycle of a qualified strobe stands for its falling edge
  wire strobe_fall  = strobe_on && !strobe_d;
  // external request counts only while internal refresh is inhibited
  wire ext_req      = !i_ext_refresh_req_n && !i_internal_refresh_inhibit_n;
  // a refresh is wanted from either source
  wire refresh_want = ext_req || int_req;
  // external request while not inhibited clears the row counter instead
  wire row_clear    = !i_ext_refresh_req_n && i_internal_refresh_inhibit_n
                      && !ext_clear_d;

  // true when a down counter has run out; refresh and wait logic share it
  function is_zero;
    input [`WAIT_W:0] value; // counter value, zero extended by the caller
    begin
      is_zero = (value == {(`WAIT_W+1){1'b0}});
    end
  endfunction

  // interval timer; its pulse feeds both the due output and internal refresh
  refresh_interval_timer u_timer (
    .i_clock       (i_clock),
    .i_resetn      (i_resetn),
    .i_long_period (i_long_period),
    .o_tick        (tick)
  );

  // mode 1 idle strobe starts the row strobe at once, else registered
  // hazard: this path is combinational from the host pins to the dram
  assign o_access_row_strobe_n = !(row_reg ||
    (state == S_IDLE && i_access_mode && strobe_on && !refresh_want));

  // an access is in flight once its row strobe is low or it is latched
  wire access_on = !o_access_row_strobe_n || pending;

  // polarity set by style: low wait until done, or low acknowledge
  // wait style stalls only while the row strobe is low or an access is pending, so
  // the first strobe cycle reads ready unless a mode 1 strobe takes an idle dram at once
  assign o_transfer_ack_n = i_ack_style_select ? !ack
                                               : (ack || !access_on);

  // arbiter: a waiting access or refresh takes an idle dram
  // refresh wins a tie so that a waiting access never delays a refresh
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (!i_access_mode && (pending || strobe_on) && !refresh_want)
          next_state = S_ACCESS;
        else if (i_access_mode && (pending || strobe_on) && !refresh_want)
          next_state = S_ACCESS;
        else if (refresh_want)
          next_state = S_REFRESH;
      end
      S_ACCESS: begin
        // the access lasts until the host drops its hold request
        if (i_access_hold_req_n && !pending)
          next_state = S_IDLE;
      end
      S_REFRESH: begin
        // leave once the row strobe length has been counted out
        if (is_zero({1'b0, rcnt}))
          next_state = S_RDONE;
      end
      S_RDONE: begin
        // back to idle; a held external request wins again there
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE; // unused code falls back to idle
      end
    endcase
  end

  // arbiter state register
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // strobe history and address capture on the strobe falling edge
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      strobe_d  <= 1'b0;
      o_address <= {`ADDR_W{1'b0}};
    end else begin
      strobe_d <= strobe_on;
      if (strobe_fall && i_addr_latch_en) begin
        o_address <= i_address;
      end
    end
  end

  // access pending latch: set by strobe with select that is not taken
  // at once, cleared when the arbiter hands the dram to the access
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pending <= 1'b0;
    end else if (strobe_on && state != S_ACCESS && next_state != S_ACCESS) begin
      pending <= 1'b1;
    end else if (next_state == S_ACCESS) begin
      pending <= 1'b0; // taken by the arbiter
    end
  end

  // internal refresh owed unless inhibited; set wins over clear
  // the due output pulses for one cycle per interval when enabled
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      int_req         <= 1'b0;
      o_refresh_due_n <= 1'b1;
    end else begin
      if (tick && i_internal_refresh_inhibit_n) begin
        int_req <= 1'b1;
      end else if (!i_internal_refresh_inhibit_n || next_state == S_REFRESH) begin
        int_req <= 1'b0; // inhibited, or served by this refresh
      end
      o_refresh_due_n <= !(tick && i_refresh_due_en);
    end
  end

  // refresh row counter: cleared by an external request edge while not
  // inhibited, advanced once at the close of every refresh
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_clear_d   <= 1'b0;
      o_refresh_row <= {`ROW_CNT_W{1'b0}};
    end else begin
      ext_clear_d <= !i_ext_refresh_req_n;
      if (row_clear) begin
        o_refresh_row <= {`ROW_CNT_W{1'b0}};
      end else if (state == S_RDONE) begin
        o_refresh_row <= o_refresh_row + 1'b1; // next row
      end
    end
  end

  // refresh sequencing: active first, strobe, then release
  // active drops one edge before the strobe and rises one edge after it
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rcnt                   <= 3'h0;
      o_refresh_row_strobe_n <= 1'b1;
      o_refresh_active_n     <= 1'b1;
    end else if (state == S_IDLE && next_state == S_REFRESH) begin
      o_refresh_active_n <= 1'b0;
      rcnt               <= `REFRESH_ROW_CYCLES;
    end else if (state == S_REFRESH) begin
      o_refresh_row_strobe_n <= is_zero({1'b0, rcnt});
      if (!is_zero({1'b0, rcnt})) begin
        rcnt <= rcnt - 1'b1; // strobe low time still running
      end
    end else if (state == S_RDONE) begin
      o_refresh_active_n <= 1'b1;
    end
  end

  // access row strobe held until hold request drops
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      row_reg <= 1'b0;
    end else begin
      row_reg <= (next_state == S_ACCESS);
    end
  end

  // wait states, extended by the extend input
  // the count reloads between accesses so each one sees the programmed waits
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wcnt <= {(`WAIT_W+1){1'b0}};
      ack  <= 1'b0;
    end else if (state != S_ACCESS) begin
      wcnt <= {1'b0, i_wait_count}; // reload while no access runs
      ack  <= 1'b0;
    end else if (!i_stall_extend_n) begin
      wcnt <= wcnt;
    end else if (!is_zero(wcnt)) begin
      wcnt <= wcnt - 1'b1;
    end else begin
      ack <= 1'b1; // waits done, access performed
    end
  end
endmodule

// [verilog/dram_port_regs.vh]
// constants for the dram access port and refresh front end
// assumes a single 50 MHz controller clock; no register bus
// Summary of operation
// - external request with inhibit asserted refreshes
// - held external request gives burst refreshes
// - external request without inhibit clears row counter
// - inhibit suppresses internal timed refreshes
// - mode 0 strobe with select sets pending
// - pending access starts at next clock edge
// - mode 1 strobe with select asserts row strobe
// - busy mode 1 strobe waits for event end
// - address captured on strobe falling edge
// - hold request negation ends access, row strobe
// - style low: wait output active low stall
// - style high: acknowledge after access performed
// - acknowledge delayed by programmed wait count
// - extend input adds clock edges to acknowledge
// - refresh due pulse every 13 or 15 us
// - refresh active brackets each refresh cycle
`ifndef DRAM_PORT_REGS_VH
`define DRAM_PORT_REGS_VH
`define CLK_MHZ          50
`define REFRESH_US_SHORT     13
`define REFRESH_US_LONG      15
`define REFRESH_CYC_SHORT    (`REFRESH_US_SHORT * `CLK_MHZ)
`define REFRESH_CYC_LONG     (`REFRESH_US_LONG * `CLK_MHZ)
`define REFRESH_RELOAD_SHORT 10'h289 // short interval cycles less one
`define REFRESH_RELOAD_LONG  10'h2ed // long interval cycles less one
`define REFRESH_ROW_CYCLES   3'h4    // refresh row strobe length
`define ROW_CNT_W            11
`define ADDR_W               24
`define WAIT_W               3
`define REFRESH_TMR_W        10
`endif

// [verilog/refresh_interval_timer.v]
// refresh interval timer: pulses once per 13 or 15 us interval
// assumes a 50 MHz clock and a level select of the interval
`timescale 1ns/1ps
`include "dram_port_regs.vh"
module refresh_interval_timer (
  input  wire i_clock,       // controller clock
  input  wire i_resetn,      // asynchronous reset, active low
  input  wire i_long_period, // high selects the 15 us interval
  output reg  o_tick         // one-cycle pulse at interval end
);
  reg  [`REFRESH_TMR_W-1:0] count;  // cycles left in interval
  wire [`REFRESH_TMR_W-1:0] reload; // interval length less one
  assign reload = i_long_period ? `REFRESH_RELOAD_LONG
                                : `REFRESH_RELOAD_SHORT;
  // count down and reload, flag the end of each interval
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      count  <= {`REFRESH_TMR_W{1'b0}};
      o_tick <= 1'b0;
    end else if (count == {`REFRESH_TMR_W{1'b0}}) begin
      count  <= reload;
      o_tick <= 1'b1;
    end else begin
      count  <= count - 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule

// [test/dram_port_checker_properties.sv]
// assertions on the ports of the dram access port and refresh front end
// assumes one clock domain and mode and wait settings held during accesses
`timescale 1ns/1ps
`include "dram_port_regs.vh"
module dram_port_checker (
  input wire i_clock, i_resetn, i_access_mode, i_ack_style_select,
  input wire [`WAIT_W-1:0] i_wait_count,
  input wire i_addr_strobe_n, i_chip_select_n, i_access_hold_req_n, i_stall_extend_n,
  input wire i_ext_refresh_req_n, i_internal_refresh_inhibit_n, o_access_row_strobe_n,
  input wire o_refresh_row_strobe_n, o_refresh_active_n, o_refresh_due_n, o_transfer_ack_n,
  input wire [`ROW_CNT_W-1:0] o_refresh_row
);
  reg  [4:0] cnt;   // cycles since the access row strobe fell
  reg        xseen; // extend seen during this access
  wire       ack_on = i_ack_style_select ? !o_transfer_ack_n : o_transfer_ack_n; // done
  wire [4:0] wq     = {2'b00, i_wait_count}; // programmed waits, widened
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // access cycle counter; saturates so a stuck access cannot wrap
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn || o_access_row_strobe_n) begin
      cnt   <= 5'h00;
      xseen <= 1'b0;
    end else begin
      cnt   <= (cnt == 5'h1f) ? cnt : cnt + 5'h01;
      xseen <= xseen | !i_stall_extend_n;
    end
  end
  sequence s_refresh_low; !o_refresh_row_strobe_n [*4] ##1 o_refresh_row_strobe_n; endsequence
  a_refresh_len: assert property ($fell(o_refresh_row_strobe_n) |-> s_refresh_low)
    else $error("refresh strobe length wrong");
  a_active_brackets: assert property (!o_refresh_row_strobe_n |-> !o_refresh_active_n)
    else $error("refresh strobe outside active");
  a_single_owner: assert property (o_access_row_strobe_n || o_refresh_row_strobe_n)
    else $error("both row strobes low");
  a_row_clear: assert property ($fell(i_ext_refresh_req_n) && i_internal_refresh_inhibit_n
    && o_refresh_active_n |-> ##[1:2] o_refresh_row == 0) else $error("row not cleared");
  a_hold_ends: assert property ($rose(i_access_hold_req_n) && i_addr_strobe_n
    && i_chip_select_n |-> ##[0:1] o_access_row_strobe_n) else $error("access not ended");
  a_strobe_now: assert property (i_access_mode && !i_addr_strobe_n && !i_chip_select_n
    && $past(i_addr_strobe_n) && o_refresh_active_n |-> !o_access_row_strobe_n)
    else $error("strobe mode access late");
  a_latch_next: assert property (!i_access_mode && !i_addr_strobe_n && !i_chip_select_n
    && $past(i_addr_strobe_n) && o_refresh_active_n |=> !o_access_row_strobe_n)
    else $error("latched access late");
  a_ack_early: assert property (!o_access_row_strobe_n && cnt <= wq |-> !ack_on)
    else $error("acknowledge too early");
  a_ack_late: assert property (!o_access_row_strobe_n && cnt == wq + 5'h01 && !xseen
    && i_stall_extend_n |-> ##[0:1] ack_on) else $error("acknowledge too late");
  a_extend_holds: assert property (!o_access_row_strobe_n && !i_stall_extend_n
    && !$past(i_stall_extend_n) && !$past(ack_on) |-> !ack_on) else $error("extend ignored");
  a_due_pulse: assert property ($fell(o_refresh_due_n) |=> o_refresh_due_n)
    else $error("due pulse too long");
endmodule
bind dram_port_access_refresh_ctl dram_port_checker chk (.*);

// [test/host_bus_model.sv]
// host bus master model driving the access port
// assumes the bench calls access while the controller clock runs
`timescale 1ns/1ps
`include "dram_port_regs.vh"
module host_bus_model (
  input  wire               i_clock,             // controller clock
  output reg                o_addr_strobe_n,     // strobe or latch enable
  output reg                o_chip_select_n,     // port select
  output reg                o_access_hold_req_n, // access hold
  output reg  [`ADDR_W-1:0] o_address            // bank row column
);
  initial begin
    o_addr_strobe_n     = 1'b1;
    o_chip_select_n     = 1'b1;
    o_access_hold_req_n = 1'b1;
    o_address           = {`ADDR_W{1'b0}};
  end
  // one access: select with strobe, hold after the first edge, then release
  task access(input [`ADDR_W-1:0] a, input integer n);
    begin
      @(posedge i_clock);
      o_addr_strobe_n <= 1'b0;
      o_chip_select_n <= 1'b0;
      o_address       <= a;
      @(posedge i_clock);
      o_access_hold_req_n <= 1'b0;
      @(posedge i_clock);
      o_addr_strobe_n <= 1'b1;
      o_chip_select_n <= 1'b1;
      o_address       <= ~a; // released bus no longer shows the address
      repeat (n) @(posedge i_clock);
      o_access_hold_req_n <= 1'b1;
    end
  endtask
endmodule

// [test/dram_port_access_refresh_ctl_tb.sv]
// self-checking bench for the dram access port and refresh front end
// assumes the host model drives the port and the checker is bound
`timescale 1ns/1ps
module dram_port_access_refresh_ctl_tb;
  reg         clk = 1'b0, rst_n = 1'b0, mode = 1'b0, sty = 1'b0, due_en = 1'b0, lp = 1'b0;
  reg   [2:0] wcnt = 3'h0;                         // programmed waits
  reg         ext_n = 1'b1, rf_n = 1'b1, inh_n = 1'b0; // extend, refresh, inhibit
  reg         latch_en = 1'b1;                     // address capture enable
  wire        as_n, cs_n, hold_n, ras_n, rras_n, ract_n, due_n, ack_n;
  wire [23:0] a_in, a_out;
  wire [10:0] row;
  integer     n_fail = 0, total_checks = 0, nack = 0, nrf = 0, ndue = 0, i, r0;
  reg  [29:0] rows [0:3]; // mode, style, waits, extend, address
  always #10 clk = ~clk;
  host_bus_model host (.i_clock(clk), .o_addr_strobe_n(as_n), .o_chip_select_n(cs_n),
    .o_access_hold_req_n(hold_n), .o_address(a_in));
  dram_port_access_refresh_ctl uut (.i_clock(clk), .i_resetn(rst_n), .i_access_mode(mode),
    .i_ack_style_select(sty), .i_wait_count(wcnt), .i_addr_latch_en(latch_en),
    .i_refresh_due_en(due_en), .i_long_period(lp), .i_addr_strobe_n(as_n),
    .i_chip_select_n(cs_n), .i_access_hold_req_n(hold_n), .i_stall_extend_n(ext_n),
    .i_ext_refresh_req_n(rf_n), .i_internal_refresh_inhibit_n(inh_n), .i_address(a_in),
    .o_address(a_out), .o_access_row_strobe_n(ras_n), .o_refresh_row_strobe_n(rras_n),
    .o_refresh_row(row), .o_refresh_active_n(ract_n), .o_refresh_due_n(due_n),
    .o_transfer_ack_n(ack_n));
  // count acknowledged cycles, refresh strobes and due pulses
  always @(posedge clk) begin
    if (!ras_n && (sty ? !ack_n : ack_n)) nack = nack + 1;
    if ($fell(rras_n)) nrf = nrf + 1;
    if ($fell(due_n)) ndue = ndue + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // watchdog: the whole run needs about 2400 cycles
  initial begin
    #100000;
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    rows[0] = {1'b0, 1'b1, 3'h0, 1'b0, 24'h000001};
    rows[1] = {1'b0, 1'b0, 3'h3, 1'b1, 24'hfff0f0};
    rows[2] = {1'b1, 1'b1, 3'h7, 1'b1, 24'h123456};
    rows[3] = {1'b1, 1'b0, 3'h2, 1'b0, 24'h800000};
    repeat (6) @(posedge clk);
    chk({ras_n, rras_n, ract_n, due_n, ack_n, row}, 32'h0000f800);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk) {mode, sty, wcnt} <= rows[i][29:25];
      nack = 0;
      fork
        host.access(rows[i][23:0], 14);
        if (rows[i][24]) begin
          @(negedge ras_n);
          @(posedge clk) ext_n <= 1'b0;
          repeat (3) @(posedge clk);
          ext_n <= 1'b1;
        end
      join
      repeat (2) @(posedge clk);
      chk(ras_n, 1);
      chk(a_out, rows[i][23:0]);
      chk(nack != 0, 1);
    end
    latch_en <= 1'b0;
    host.access(24'h0abcde, 2);
    repeat (2) @(posedge clk);
    chk(a_out, rows[3][23:0]);
    r0 = row;
    @(posedge clk) rf_n <= 1'b0;
    @(posedge clk) rf_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(row, r0 + 1);
    r0 = nrf;
    rf_n <= 1'b0;
    repeat (20) @(posedge clk);
    rf_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(nrf - r0 > 1, 1);
    inh_n <= 1'b1;
    @(posedge clk) rf_n <= 1'b0;
    @(posedge clk) rf_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(row, 0);
    due_en <= 1'b1;
    inh_n <= 1'b0;
    r0 = nrf;
    repeat (1400) @(posedge clk);
    chk(nrf - r0, 0);
    chk(ndue > 1, 1);
    inh_n <= 1'b1;
    lp <= 1'b1;
    r0 = nrf;
    repeat (850) @(posedge clk);
    chk(nrf - r0 > 0, 1);
    test_done;
  end
endmodule
